/* common/i2c_port_cfg.svh */
// register offsets, field positions, reset values and counts of the serial port control block
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH
`define OFS_CTRL1      8'h00
`define OFS_CTRL2      8'h04
`define OFS_STATUS     8'h08
`define OFS_BUFFER     8'h0c
`define OFS_ADDR       8'h10
`define B_WRITE_COLLISION_FLAG         7
`define B_OVF          6
`define B_EN           5
`define B_CKP          4
`define B_GENERAL_CALL_ENABLE         7
`define B_ACK_RECEIVED_STATUS      6
`define B_ACK_DATA_VALUE        5
`define B_ACK_SEQUENCE_REQUEST        4
`define B_RECEIVE_REQUEST         3
`define B_PEN          2
`define B_REPEATED_START_REQUEST         1
`define B_SEN          0
`define B_FULL         0
`define B_BUSY         1
`define B_EVENT        2
`define RST_CTRL       8'h00
`define RST_ADDR       8'h00
`define RST_MASK       8'hff
`define GC_ADDR        8'h00
`define BITS_PER_BYTE  4'd8
`endif

/* common/i2c_port_pkg.sv */
// types shared by the serial port control block
package i2c_port_pkg;
	typedef enum logic [3:0] {
		MODE_SLAVE7      = 4'h6,
		MODE_SLAVE10     = 4'h7,
		MODE_MASTER      = 4'h8,
		MODE_MASK_ACCESS = 4'h9,
		MODE_FW_MASTER   = 4'hb,
		MODE_SLAVE7_SS   = 4'he,
		MODE_SLAVE10_SS  = 4'hf
	} mode_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} pin_pair_t;
	typedef enum logic [2:0] {M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK} master_state_t;
	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TACK} slave_state_t;
endpackage : i2c_port_pkg

/* hdl/i2c_serial_port_control.sv */
// serial port control: apb registers, i2c master sequencer and slave byte engine
//
// The register addresses and the APB register port are this design's own decisions.
`include "i2c_port_cfg.svh"

module i2c_serial_port_control (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output      logic [31:0]             prdata,
	output      logic                    pready,
	output      logic                    pslverr,
	// configuration strap, high selects 7-bit masking
	input  wire logic                    mask_mode_config,
	// open-drain bus pins
	input  wire i2c_port_pkg::pin_pair_t pin_in,
	output      i2c_port_pkg::pin_pair_t pin_out,
	output      i2c_port_pkg::pin_pair_t pin_oe,
	output      logic                    pin_owner
);
	// ****************************************
	// pin and strap synchronisers
	// ****************************************
	i2c_port_pkg::pin_pair_t pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic mm_meta_reg, mm_sync_reg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta_reg <= 2'b11;
			pin_sync_reg <= 2'b11;
			pin_prev_reg <= 2'b11;
			mm_meta_reg  <= 1'b0;
			mm_sync_reg  <= 1'b0;
		end else begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
			mm_meta_reg  <= mask_mode_config;
			mm_sync_reg  <= mm_meta_reg;
		end
	end

	// ****************************************
	// core state
	// ****************************************
	logic [7:0]                  ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
	logic [7:0]                  buf_reg, buf_next, addr_reg, addr_next, mask_reg, mask_next;
	logic [7:0]                  sh_reg, sh_next, baud_reg, baud_next;
	logic [3:0]                  bit_reg, bit_next;
	logic [1:0]                  q_reg, q_next;
	logic                        full_reg, full_next, evt_reg, evt_next, owned_reg, owned_next;
	logic                        s_addr_reg, s_addr_next, s_rw_reg, s_rw_next;
	logic                        owner_reg, owner_next, pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0]                 prdata_reg, prdata_next;
	i2c_port_pkg::pin_pair_t     oe_reg, oe_next, out_reg;
	i2c_port_pkg::master_state_t m_state, m_next;
	i2c_port_pkg::slave_state_t  s_state, s_next;
	i2c_port_pkg::mode_t         mode;
	logic en, master_on, slave_on, ss_mode, mask_access, busy, tick;
	logic acc, wr, rd, scl_rise, scl_fall, start_det, stop_det;
	logic match, gc_hit, set_write_collision_flag, set_ovf, set_evt, load_buf, m_scl_low, m_sda_low, s_sda_low;

	assign mode        = i2c_port_pkg::mode_t'(ctrl1_reg[3:0]);
	assign en          = ctrl1_reg[`B_EN];
	assign master_on   = en && mode == i2c_port_pkg::MODE_MASTER;
	// firmware master mode enables neither engine
	assign slave_on    = en && (mode == i2c_port_pkg::MODE_SLAVE7 || mode == i2c_port_pkg::MODE_SLAVE10 ||
	                     mode == i2c_port_pkg::MODE_SLAVE7_SS || mode == i2c_port_pkg::MODE_SLAVE10_SS);
	assign ss_mode     = mode == i2c_port_pkg::MODE_SLAVE7_SS || mode == i2c_port_pkg::MODE_SLAVE10_SS;
	assign mask_access = mode == i2c_port_pkg::MODE_MASK_ACCESS && mm_sync_reg;
	assign busy        = m_state != i2c_port_pkg::M_IDLE;
	assign tick        = baud_reg == 8'h00;
	assign acc         = psel && penable && pready_reg;
	assign wr          = acc && pwrite;
	assign rd          = acc && !pwrite;
	assign scl_rise    = pin_sync_reg.scl && !pin_prev_reg.scl;
	assign scl_fall    = !pin_sync_reg.scl && pin_prev_reg.scl;
	assign start_det   = pin_sync_reg.scl && pin_prev_reg.scl && pin_prev_reg.sda && !pin_sync_reg.sda;
	assign stop_det    = pin_sync_reg.scl && pin_prev_reg.scl && !pin_prev_reg.sda && pin_sync_reg.sda;
	// 10-bit slaves compare only the first byte after a start, the same way as 7-bit; later bytes are taken as data
	assign match       = ((sh_reg[7:1] ^ addr_reg[7:1]) & ~(mm_sync_reg ? mask_reg[7:1] : 7'h00)) == 7'h00;
	assign gc_hit      = sh_reg == `GC_ADDR && ctrl2_reg[`B_GENERAL_CALL_ENABLE];

	always_comb begin
		ctrl1_next  = ctrl1_reg;
		ctrl2_next  = ctrl2_reg;
		buf_next    = buf_reg;
		addr_next   = addr_reg;
		mask_next   = mask_reg;
		sh_next     = sh_reg;
		bit_next    = bit_reg;
		q_next      = q_reg;
		full_next   = full_reg;
		evt_next    = evt_reg;
		owned_next  = owned_reg;
		s_addr_next = s_addr_reg;
		s_rw_next   = s_rw_reg;
		m_next      = m_state;
		s_next      = s_state;
		set_write_collision_flag    = 1'b0;
		set_ovf     = 1'b0;
		set_evt     = 1'b0;
		load_buf    = 1'b0;
		m_scl_low   = 1'b0;
		m_sda_low   = 1'b0;
		s_sda_low   = 1'b0;
		// quarter bit time is reload plus one cycles, so a bit takes 4*(n+1)
		baud_next   = (tick || !master_on) ? addr_reg : baud_reg - 8'h01;

		// ****************************************
		// master sequencer
		// ****************************************
		case (m_state)
			i2c_port_pkg::M_IDLE: begin
				m_scl_low = owned_reg;
				m_sda_low = owned_reg;
				q_next = 2'd0;
				if (master_on) begin
					if (ctrl2_reg[`B_SEN])
						m_next = i2c_port_pkg::M_START;
					else if (ctrl2_reg[`B_REPEATED_START_REQUEST])
						m_next = i2c_port_pkg::M_RSTART;
					else if (ctrl2_reg[`B_PEN])
						m_next = i2c_port_pkg::M_STOP;
					else if (ctrl2_reg[`B_RECEIVE_REQUEST]) begin
						m_next = i2c_port_pkg::M_RX;
						bit_next = 4'd0;
					end else if (ctrl2_reg[`B_ACK_SEQUENCE_REQUEST])
						m_next = i2c_port_pkg::M_ACK;
				end
			end
			i2c_port_pkg::M_START: begin
				m_sda_low = q_reg[1];
				m_scl_low = q_reg == 2'd3;
			end
			i2c_port_pkg::M_RSTART: begin
				m_sda_low = q_reg[1];
				m_scl_low = q_reg == 2'd0 || q_reg == 2'd3;
			end
			i2c_port_pkg::M_STOP: begin
				m_sda_low = !q_reg[1];
				m_scl_low = q_reg == 2'd0;
			end
			i2c_port_pkg::M_TX: begin
				m_scl_low = q_reg == 2'd0 || q_reg == 2'd3;
				m_sda_low = bit_reg != `BITS_PER_BYTE && !sh_reg[7];
			end
			i2c_port_pkg::M_RX: begin
				m_scl_low = q_reg == 2'd0 || q_reg == 2'd3;
			end
			i2c_port_pkg::M_ACK: begin
				m_scl_low = q_reg == 2'd0 || q_reg == 2'd3;
				m_sda_low = !ctrl2_reg[`B_ACK_DATA_VALUE];
			end
			default: m_next = i2c_port_pkg::M_IDLE;
		endcase
		if (busy && tick) begin
			q_next = q_reg + 2'd1;
			if (q_reg == 2'd2 && m_state == i2c_port_pkg::M_TX && bit_reg == `BITS_PER_BYTE)
				ctrl2_next[`B_ACK_RECEIVED_STATUS] = pin_sync_reg.sda;
			if (q_reg == 2'd2 && m_state == i2c_port_pkg::M_RX)
				sh_next = {sh_reg[6:0], pin_sync_reg.sda};
			if (q_reg == 2'd3) begin
				bit_next = bit_reg + 4'd1;
				if (m_state == i2c_port_pkg::M_TX)
					sh_next = {sh_reg[6:0], 1'b0};
				case (m_state)
					i2c_port_pkg::M_START: begin
						ctrl2_next[`B_SEN] = 1'b0;
						owned_next = 1'b1;
						m_next = i2c_port_pkg::M_IDLE;
					end
					i2c_port_pkg::M_RSTART: begin
						ctrl2_next[`B_REPEATED_START_REQUEST] = 1'b0;
						m_next = i2c_port_pkg::M_IDLE;
					end
					i2c_port_pkg::M_STOP: begin
						ctrl2_next[`B_PEN] = 1'b0;
						owned_next = 1'b0;
						m_next = i2c_port_pkg::M_IDLE;
					end
					i2c_port_pkg::M_ACK: begin
						ctrl2_next[`B_ACK_SEQUENCE_REQUEST] = 1'b0;
						m_next = i2c_port_pkg::M_IDLE;
					end
					i2c_port_pkg::M_TX: if (bit_reg == `BITS_PER_BYTE) begin
						// the sent byte no longer counts as unread, so a later receive is not an overflow
						full_next = 1'b0;
						m_next = i2c_port_pkg::M_IDLE;
					end
					i2c_port_pkg::M_RX: if (bit_reg == `BITS_PER_BYTE - 4'd1) begin
						ctrl2_next[`B_RECEIVE_REQUEST] = 1'b0;
						m_next = i2c_port_pkg::M_IDLE;
						if (full_reg || ctrl1_reg[`B_OVF])
							set_ovf = 1'b1;
						else
							load_buf = 1'b1;
					end
					default: m_next = i2c_port_pkg::M_IDLE;
				endcase
			end
		end

		// ****************************************
		// slave byte engine
		// ****************************************
		if (slave_on && start_det) begin
			s_next = i2c_port_pkg::S_RX;
			bit_next = 4'd0;
			s_addr_next = 1'b1;
			set_evt = ss_mode;
		end else if (slave_on && stop_det) begin
			s_next = i2c_port_pkg::S_IDLE;
			set_evt = ss_mode;
		end else if (slave_on) begin
			case (s_state)
				i2c_port_pkg::S_IDLE: ;
				i2c_port_pkg::S_RX: begin
					if (scl_rise) begin
						sh_next = {sh_reg[6:0], pin_sync_reg.sda};
						bit_next = bit_reg + 4'd1;
					end
					if (scl_fall && bit_reg == `BITS_PER_BYTE) begin
						bit_next = 4'd0;
						if (s_addr_reg && !(match || gc_hit))
							s_next = i2c_port_pkg::S_IDLE;
						else if (full_reg || ctrl1_reg[`B_OVF]) begin
							set_ovf = 1'b1;
							if (s_addr_reg)
								s_next = i2c_port_pkg::S_IDLE;
						end else begin
							load_buf = 1'b1;
							set_evt = 1'b1;
							s_next = i2c_port_pkg::S_ACK;
							if (s_addr_reg)
								s_rw_next = sh_reg[0] && !gc_hit;
						end
					end
				end
				i2c_port_pkg::S_ACK: begin
					s_sda_low = 1'b1;
					if (scl_fall) begin
						s_addr_next = 1'b0;
						bit_next = 4'd0;
						if (ctrl2_reg[`B_SEN])
							ctrl1_next[`B_CKP] = 1'b0;
						if (s_rw_reg) begin
							s_next = i2c_port_pkg::S_TX;
							sh_next = buf_reg;
							full_next = 1'b0;
						end else
							s_next = i2c_port_pkg::S_RX;
					end
				end
				i2c_port_pkg::S_TX: begin
					s_sda_low = !sh_reg[7];
					if (scl_fall) begin
						sh_next = {sh_reg[6:0], 1'b0};
						bit_next = bit_reg + 4'd1;
						if (bit_reg == `BITS_PER_BYTE - 4'd1)
							s_next = i2c_port_pkg::S_TACK;
					end
				end
				i2c_port_pkg::S_TACK: begin
					if (scl_rise && pin_sync_reg.sda)
						s_next = i2c_port_pkg::S_IDLE;
					else if (scl_fall) begin
						s_next = i2c_port_pkg::S_TX;
						bit_next = 4'd0;
						sh_next = buf_reg;
						full_next = 1'b0;
						if (ctrl2_reg[`B_SEN])
							ctrl1_next[`B_CKP] = 1'b0;
					end
				end
				default: s_next = i2c_port_pkg::S_IDLE;
			endcase
		end else
			s_next = i2c_port_pkg::S_IDLE;
		if (!en) begin
			m_next = i2c_port_pkg::M_IDLE;
			owned_next = 1'b0;
		end
		if (load_buf) begin
			buf_next = sh_reg;
			full_next = 1'b1;
		end

		// ****************************************
		// software access
		// ****************************************
		if (rd && paddr == `OFS_BUFFER)
			full_next = 1'b0;
		if (wr) begin
			case (paddr)
				`OFS_CTRL1: ctrl1_next = pwdata[7:0];
				`OFS_CTRL2: begin
					ctrl2_next[`B_GENERAL_CALL_ENABLE] = pwdata[`B_GENERAL_CALL_ENABLE];
					ctrl2_next[`B_ACK_DATA_VALUE] = pwdata[`B_ACK_DATA_VALUE];
					// requests are not queued: writes to them are dropped while busy
					if (!(master_on && busy))
						ctrl2_next[4:0] = pwdata[4:0];
				end
				`OFS_STATUS: if (pwdata[`B_EVENT]) evt_next = 1'b0;
				`OFS_BUFFER: begin
					if (master_on && (busy || !owned_reg || ctrl2_reg[4:0] != 5'h00))
						set_write_collision_flag = 1'b1;
					else if (slave_on && (s_state == i2c_port_pkg::S_TX || s_state == i2c_port_pkg::S_TACK))
						set_write_collision_flag = 1'b1;
					else begin
						buf_next = pwdata[7:0];
						full_next = 1'b1;
						if (master_on) begin
							sh_next = pwdata[7:0];
							bit_next = 4'd0;
							m_next = i2c_port_pkg::M_TX;
						end
					end
				end
				`OFS_ADDR: begin
					if (mask_access)
						mask_next = pwdata[7:0];
					else
						addr_next = pwdata[7:0];
				end
				default: ;
			endcase
		end
		// hardware sets win over a clearing write in the same cycle
		ctrl1_next[`B_WRITE_COLLISION_FLAG] = ctrl1_next[`B_WRITE_COLLISION_FLAG] | set_write_collision_flag;
		ctrl1_next[`B_OVF] = ctrl1_next[`B_OVF] | set_ovf;
		evt_next = evt_next | set_evt;

		// ****************************************
		// pins and apb answer
		// ****************************************
		owner_next = en;
		oe_next.scl = en && (master_on ? m_scl_low : (slave_on && s_state != i2c_port_pkg::S_IDLE &&
		              !ctrl1_reg[`B_CKP]));
		oe_next.sda = en && (master_on ? m_sda_low : (slave_on && s_sda_low));
		pready_next = psel && !penable;
		pslverr_next = 1'b0;
		prdata_next = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				`OFS_CTRL1: prdata_next[7:0] = ctrl1_reg;
				`OFS_CTRL2: prdata_next[7:0] = ctrl2_reg;
				`OFS_STATUS: prdata_next[2:0] = {evt_reg, busy, full_reg};
				`OFS_BUFFER: prdata_next[7:0] = buf_reg;
				`OFS_ADDR: prdata_next[7:0] = mask_access ? mask_reg : addr_reg;
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl1_reg   <= `RST_CTRL;
			ctrl2_reg   <= `RST_CTRL;
			buf_reg     <= 8'h00;
			addr_reg    <= `RST_ADDR;
			mask_reg    <= `RST_MASK;
			sh_reg      <= 8'h00;
			baud_reg    <= `RST_ADDR;
			bit_reg     <= 4'd0;
			q_reg       <= 2'd0;
			full_reg    <= 1'b0;
			evt_reg     <= 1'b0;
			owned_reg   <= 1'b0;
			s_addr_reg  <= 1'b0;
			s_rw_reg    <= 1'b0;
			owner_reg   <= 1'b0;
			oe_reg      <= 2'b00;
			out_reg     <= 2'b00;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			m_state     <= i2c_port_pkg::M_IDLE;
			s_state     <= i2c_port_pkg::S_IDLE;
		end else begin
			ctrl1_reg   <= ctrl1_next;
			ctrl2_reg   <= ctrl2_next;
			buf_reg     <= buf_next;
			addr_reg    <= addr_next;
			mask_reg    <= mask_next;
			sh_reg      <= sh_next;
			baud_reg    <= baud_next;
			bit_reg     <= bit_next;
			q_reg       <= q_next;
			full_reg    <= full_next;
			evt_reg     <= evt_next;
			owned_reg   <= owned_next;
			s_addr_reg  <= s_addr_next;
			s_rw_reg    <= s_rw_next;
			owner_reg   <= owner_next;
			oe_reg      <= oe_next;
			out_reg     <= 2'b00;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
			m_state     <= m_next;
			s_state     <= s_next;
		end
	end

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign pin_out   = out_reg;
	assign pin_oe    = oe_reg;
	assign pin_owner = owner_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	pins_owned_a: assert property (en |=> pin_owner) else $error("pins not handed to port");
	pins_freed_a: assert property (!en |=> !pin_owner && pin_oe == 2'b00)
		else $error("pins driven while disabled");
	stretch_hold_a: assert property (slave_on && s_state != i2c_port_pkg::S_IDLE && !ctrl1_reg[`B_CKP]
		|=> pin_oe.scl) else $error("slave clock not held");
	master_write_collision_flag_a: assert property (wr && paddr == `OFS_BUFFER && master_on && busy && !tick
		|=> ctrl1_reg[`B_WRITE_COLLISION_FLAG] && m_state == $past(m_state)) else $error("master collision missed");
	slave_write_collision_flag_a: assert property (wr && paddr == `OFS_BUFFER && slave_on && s_state == i2c_port_pkg::S_TX
		|=> ctrl1_reg[`B_WRITE_COLLISION_FLAG]) else $error("slave collision missed");
	overflow_set_a: assert property (set_ovf && !(wr && paddr == `OFS_BUFFER)
		|=> ctrl1_reg[`B_OVF] && buf_reg == $past(buf_reg)) else $error("overflow lost or buffer overwritten");
	start_done_a: assert property (m_state == i2c_port_pkg::M_START && tick && q_reg == 2'd3
		|=> !ctrl2_reg[`B_SEN] && owned_reg) else $error("start request not cleared");
	stop_done_a: assert property (m_state == i2c_port_pkg::M_STOP && tick && q_reg == 2'd3
		|=> !ctrl2_reg[`B_PEN] && !owned_reg) else $error("stop request not cleared");
	baud_reload_a: assert property (master_on && tick |=> baud_reg == $past(addr_reg))
		else $error("baud reload wrong");
	mask_redirect_a: assert property (wr && paddr == `OFS_ADDR && mask_access
		|=> mask_reg == $past(pwdata[7:0]) && addr_reg == $past(addr_reg)) else $error("mask write misrouted");
endmodule : i2c_serial_port_control

/* verif/i2c_target_model.sv */
// behavioural i2c target answering one address, with a fixed byte for reads
module i2c_target_model #(
	parameter logic [6:0] TARGET_ADDR = 7'h2a,
	parameter logic [7:0] READ_BYTE   = 8'h96
) (
	// wire levels
	input  wire logic       scl,
	input  wire logic       sda,
	// open-drain pull on data, last byte written to us
	output      logic       sda_oe,
	output      logic [7:0] last_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] shift;

	task automatic get_byte();
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			shift = {shift[6:0], sda};
		end
		@(negedge scl);
	endtask : get_byte

	task automatic pulse_ack();
		sda_oe = 1'b1;
		@(negedge scl);
		sda_oe = 1'b0;
	endtask : pulse_ack

	task automatic run_transfer();
		get_byte();
		if (shift[7:1] == TARGET_ADDR) begin
			pulse_ack();
			if (shift[0]) begin
				for (int i = 7; i >= 0; i--) begin
					sda_oe = ~READ_BYTE[i];
					@(negedge scl);
				end
				sda_oe = 1'b0;
			end else begin
				forever begin
					get_byte();
					last_rx = shift;
					pulse_ack();
				end
			end
		end
		// a wrong address leaves the line released until the next start
		wait (1'b0);
	endtask : run_transfer

	// any start aborts the transfer in flight, as a real target must
	initial begin
		sda_oe = 1'b0;
		last_rx = 8'h00;
		shift = 8'h00;
		@(negedge sda iff scl === 1'b1);
		forever begin
			fork
				run_transfer();
				@(negedge sda iff scl === 1'b1);
			join_any
			disable fork;
			sda_oe = 1'b0;
		end
	end
endmodule : i2c_target_model

/* verif/tb.sv */
// testbench: apb register checks, master bus sequences against the target model and a slave transfer from an external master
`include "i2c_port_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BAUD = 1;
	logic                    ref_clk, nrst, psel, penable, pwrite, mask_mode_config;
	logic [7:0]              paddr, rv, tgt_rx;
	logic [31:0]             pwdata, prdata;
	logic                    pready, pslverr, pin_owner, tgt_oe, scl, sda, last_sda, ext_scl_oe, ext_sda_oe;
	i2c_port_pkg::pin_pair_t pin_in, pin_out, pin_oe;
	int                      n_errors, n_tests, n_starts, n_stops;
	realtime                 t_rise, scl_per;

	// lines are pulled up unless someone pulls low
	assign scl = (pin_oe.scl === 1'b1 || ext_scl_oe === 1'b1) ? 1'b0 : 1'b1;
	assign sda = (pin_oe.sda === 1'b1 || tgt_oe === 1'b1 || ext_sda_oe === 1'b1) ? 1'b0 : 1'b1;
	assign pin_in = {scl, sda};

	i2c_serial_port_control u_i2c_serial_port_control (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mask_mode_config(mask_mode_config), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_owner(pin_owner));
	i2c_target_model u_i2c_target_model (.scl(scl), .sda(sda), .sda_oe(tgt_oe), .last_rx(tgt_rx));

	always @(negedge sda) if (scl === 1'b1 && nrst === 1'b1) n_starts++;
	always @(posedge sda) if (scl === 1'b1 && nrst === 1'b1) n_stops++;
	always @(posedge scl) begin
		last_sda = sda;
		scl_per = $realtime - t_rise;
		t_rise = $realtime;
	end

	// ************************************************************
	// bus access and comparison
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic e;
		apb(1'b0, a, 8'h00, rv, e);
	endtask : rd

	// polling keeps the master free of any assumed sequence length
	task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
		int k;
		wr(a, d);
		k = 0;
		do begin
			rd(`OFS_STATUS);
			k++;
		end while (rv[`B_BUSY] !== 1'b0 && k < 500);
		if (rv[`B_BUSY] !== 1'b0) begin
			n_errors++;
			$display("ERROR at %0t ns: sequencer stayed busy", $time);
		end
	endtask : wr_wait

	// external master: each step holds the lines long enough for the pin synchronisers
	task automatic bus_step(input logic c, input logic d);
		ext_scl_oe <= !c;
		ext_sda_oe <= !d;
		repeat (6) @(posedge ref_clk);
	endtask : bus_step

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		logic e;
		rd(`OFS_CTRL1);
		chk(rv, `RST_CTRL);
		rd(`OFS_CTRL2);
		chk(rv, `RST_CTRL);
		apb(1'b1, 8'h14, 8'h5a, rv, e);
		chk(e, 1'b1);
		chk(pin_owner, 1'b0);
	endtask : t_regs

	task automatic t_modes();
		logic [3:0] codes [6] = '{4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
		foreach (codes[i]) begin
			wr(`OFS_CTRL1, {4'h3, codes[i]});
			rd(`OFS_CTRL1);
			chk(rv, {4'h3, codes[i]});
			chk(pin_owner, 1'b1);
		end
		wr(`OFS_CTRL1, 8'h18);
		@(posedge ref_clk);
		chk(pin_owner, 1'b0);
		chk(pin_oe, 2'b00);
	endtask : t_modes

	task automatic t_mask();
		wr(`OFS_CTRL1, 8'h29);
		wr(`OFS_ADDR, 8'h5a);
		rd(`OFS_ADDR);
		chk(rv, 8'h5a);
		wr(`OFS_CTRL1, 8'h28);
		rd(`OFS_ADDR);
		chk(rv, `RST_ADDR);
		mask_mode_config <= 1'b0;
		repeat (4) @(posedge ref_clk);
		wr(`OFS_CTRL1, 8'h29);
		wr(`OFS_ADDR, 8'h3c);
		wr(`OFS_CTRL1, 8'h28);
		rd(`OFS_ADDR);
		chk(rv, 8'h3c);
		mask_mode_config <= 1'b1;
		wr(`OFS_ADDR, BAUD[7:0]);
	endtask : t_mask

	task automatic t_master();
		wr(`OFS_BUFFER, 8'h11);
		rd(`OFS_CTRL1);
		chk(rv, 8'ha8);
		wr(`OFS_CTRL1, 8'h28);
		wr_wait(`OFS_CTRL2, 8'h01);
		rd(`OFS_CTRL2);
		chk(rv, 8'h00);
		chk(n_starts, 1);
		wr_wait(`OFS_BUFFER, 8'h20);
		rd(`OFS_CTRL2);
		chk(rv, 8'h40);
		wr_wait(`OFS_CTRL2, 8'h02);
		chk(n_starts, 2);
		wr(`OFS_BUFFER, 8'h54);
		wr(`OFS_BUFFER, 8'h77);
		wr_wait(`OFS_CTRL2, 8'h04);
		rd(`OFS_CTRL1);
		chk(rv, 8'ha8);
		rd(`OFS_CTRL2);
		chk(rv, 8'h00);
		chk(n_stops, 0);
		wr(`OFS_CTRL1, 8'h28);
		wr_wait(`OFS_BUFFER, 8'hc3);
		chk(tgt_rx, 8'hc3);
		chk(int'(scl_per), 4 * (BAUD + 1) * 5);
		wr_wait(`OFS_CTRL2, 8'h02);
		wr_wait(`OFS_BUFFER, 8'h55);
		wr_wait(`OFS_CTRL2, 8'h08);
		rd(`OFS_CTRL2);
		chk(rv, 8'h00);
		rd(`OFS_BUFFER);
		chk(rv, 8'h96);
		wr_wait(`OFS_CTRL2, 8'h30);
		rd(`OFS_CTRL2);
		chk(rv, 8'h20);
		chk(last_sda, 1'b1);
		wr_wait(`OFS_CTRL2, 8'h08);
		wr_wait(`OFS_CTRL2, 8'h08);
		rd(`OFS_CTRL1);
		chk(rv, 8'h68);
		rd(`OFS_BUFFER);
		chk(rv, 8'hff);
		wr_wait(`OFS_CTRL2, 8'h24);
		rd(`OFS_CTRL2);
		chk(rv, 8'h20);
		chk(n_stops, 1);
		chk({scl, sda}, 2'b11);
	endtask : t_master

	task automatic t_slave();
		logic [7:0] b;
		b = 8'h3a;
		wr(`OFS_CTRL1, 8'h36);
		wr(`OFS_ADDR, b);
		wr(`OFS_CTRL2, 8'h01);
		bus_step(1'b1, 1'b0);
		bus_step(1'b0, 1'b0);
		rd(`OFS_STATUS);
		chk(rv[`B_EVENT], 1'b0);
		for (int i = 7; i >= 0; i--) begin
			bus_step(1'b0, b[i]);
			bus_step(1'b1, b[i]);
			bus_step(1'b0, b[i]);
		end
		bus_step(1'b0, 1'b1);
		bus_step(1'b1, 1'b1);
		chk(pin_oe.sda, 1'b1);
		bus_step(1'b0, 1'b1);
		rd(`OFS_CTRL1);
		chk(rv, 8'h26);
		rd(`OFS_STATUS);
		chk(rv[2:0], 3'b101);
		bus_step(1'b1, 1'b1);
		chk(scl, 1'b0);
		wr(`OFS_CTRL1, 8'h36);
		bus_step(1'b1, 1'b1);
		chk(scl, 1'b1);
		bus_step(1'b0, 1'b1);
		bus_step(1'b0, 1'b0);
		bus_step(1'b1, 1'b0);
		bus_step(1'b1, 1'b1);
		chk(pin_oe, 2'b00);
	endtask : t_slave

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_scl_oe, ext_sda_oe} = 2'b00;
		mask_mode_config = 1'b1;
		{n_errors, n_tests, n_starts, n_stops} = '0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_modes();
		t_mask();
		t_master();
		t_slave();
		report_and_stop();
	end

	// whole run needs about a thousand cycles
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule : tb
